// ==== rtl/swflt_top.sv ====
// Operation
// - The low trip level is chosen from eight codes and the high trip level from two codes by configuration.
// - Low and high current comparisons are watched at the same time and each can trip on its own.
// - Current at the low level for longer than the blanking period latches the output off and records a fault.
// - Current at the high level latches the fault and turns the output off at once, with no blanking.
// - After any overcurrent trip the output stays off until the command goes off and then on again.
// - The effective command is the direct drive input or the serial command bit, whichever asks for on.
// - Loss of ground turns the output off whatever state it was in.
// - Supply below threshold with protection enabled turns the output off, pulls the fault pin low and sets the flag.
// - If the command is still on at supply recovery, pin and output stay faulted until the command cycles; flag holds until read.
// - With supply protection disabled, neither pin nor flag report and the output is not changed by low supply.
// - The fault pin releases when a fault clears, except after overcurrent or a supply fault with the command on, where it stays low until the latch releases.
`timescale 1ns/1ps
`default_nettype none
`include "swflt_consts.svh"
module swflt_top
  import swflt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic drive_i,
  input wire logic [7:0] low_trip_current_i,
  input wire logic [1:0] high_trip_current_i,
  input wire logic supply_low_i,
  input wire logic gnd_lost_i,
  output logic switch_on_o,
  output logic fault_indicator_n_o,
  output logic irq_o
);

  swflt_state_type st_q, st_d;
  swflt_sense_type sense;
  swflt_cfg_type cfg;
  logic [31:0] ctrl, cfg_word, stat;
  logic cmd, supply_low_protect_disable, uv_act, low_over, high_over, low_exp;
  logic oc_trip, uv_latched_q, uv_latched_d, flag_q, flag_d;
  logic on_q, on_d, fs_n_q, fs_n_d, flag_read;
  logic [3:0] events;

  assign sense = '{low_reached: low_trip_current_i[cfg.low_sel],
                   high_reached: high_trip_current_i[cfg.high_sel],
                   supply_low: supply_low_i,
                   gnd_lost: gnd_lost_i};
  assign cfg = '{low_sel: cfg_word[`SWFLT_CFG_LOW_LSB +: 3],
                 high_sel: cfg_word[`SWFLT_CFG_HIGH],
                 blank_sel: cfg_word[`SWFLT_CFG_BLANK_LSB +: 2]};

  assign cmd = drive_i | ctrl[`SWFLT_CTRL_CMD];
  assign supply_low_protect_disable = ctrl[`SWFLT_CTRL_UVDIS];
  assign uv_act = sense.supply_low && !supply_low_protect_disable;
  // Both comparisons only matter while driving; they run side by side
  assign low_over = (st_q == SWFLT_ON) && sense.low_reached;
  assign high_over = (st_q == SWFLT_ON) && sense.high_reached;
  assign oc_trip = high_over || low_exp;

  swflt_blank_timer u_blank (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(clk_en_i),
    .over_i(low_over),
    .sel_i(cfg.blank_sel),
    .expired_o(low_exp)
  );

  always_comb begin
    st_d = st_q;
    uv_latched_d = uv_latched_q;
    case (st_q)
      SWFLT_OFF: begin
        if (cmd && !uv_act && !sense.gnd_lost && !uv_latched_q) begin
          st_d = SWFLT_ON;
        end
      end
      SWFLT_ON: begin
        if (!cmd) begin
          st_d = SWFLT_OFF;
        end else if (oc_trip) begin
          st_d = SWFLT_TRIP;
        end else if (sense.gnd_lost) begin
          st_d = SWFLT_OFF;
        end else if (uv_act) begin
          st_d = SWFLT_OFF;
        end
      end
      // Latched off until the command is seen off
      SWFLT_TRIP: begin
        if (!cmd) begin
          st_d = SWFLT_WAIT_OFF;
        end
      end
      SWFLT_WAIT_OFF: begin
        st_d = SWFLT_OFF;
      end
      default: st_d = SWFLT_OFF;
    endcase
    // Low supply with command on latches until the command drops
    if (uv_act && cmd) begin
      uv_latched_d = 1'b1;
    end else if (!cmd) begin
      uv_latched_d = 1'b0;
    end
    flag_d = flag_q;
    if (flag_read) begin
      flag_d = 1'b0;
    end
    if (uv_act) begin
      flag_d = 1'b1;
    end
    on_d = (st_d == SWFLT_ON);
    // Pin follows live supply faults, not ground loss, but overcurrent and latched supply faults hold it
    fs_n_d = !(uv_act || uv_latched_d || st_d == SWFLT_TRIP);
  end

  assign events = {sense.gnd_lost && st_q == SWFLT_ON, uv_act && !flag_q,
                   high_over, low_exp && !high_over};
  assign stat = {26'h0, uv_latched_q, flag_q, !fs_n_q, st_q == SWFLT_TRIP, st_q};

  swflt_apb_regs u_regs (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(clk_en_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .events_i(events),
    .stat_i(stat),
    .uv_flag_i(flag_q),
    .ctrl_o(ctrl),
    .cfg_o(cfg_word),
    .flag_read_o(flag_read),
    .irq_o(irq_o)
  );

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= SWFLT_OFF;
      uv_latched_q <= 1'b0;
      flag_q <= 1'b0;
      on_q <= 1'b0;
      fs_n_q <= 1'b1;
    end else if (clk_en_i) begin
      st_q <= st_d;
      uv_latched_q <= uv_latched_d;
      flag_q <= flag_d;
      on_q <= on_d;
      fs_n_q <= fs_n_d;
    end
  end

  assign switch_on_o = on_q;
  assign fault_indicator_n_o = fs_n_q;

  a_high_trip_now: assert property (@(posedge clk_i) disable iff (!rstn_i)
    clk_en_i && st_q == SWFLT_ON && sense.high_reached && cmd |=> !switch_on_o && st_q == SWFLT_TRIP)
    else $error("high trip did not act at once");
  a_low_trip_latch: assert property (@(posedge clk_i) disable iff (!rstn_i)
    clk_en_i && low_exp && cmd |=> st_q == SWFLT_TRIP) else $error("low trip not latched");
  a_trip_holds_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    st_q == SWFLT_TRIP && cmd |=> !switch_on_o) else $error("output on while tripped");
  a_trip_pin_low: assert property (@(posedge clk_i) disable iff (!rstn_i)
    clk_en_i && st_q == SWFLT_TRIP && cmd |=> !fault_indicator_n_o) else $error("pin released in trip");
  a_gnd_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    clk_en_i && sense.gnd_lost |=> !switch_on_o) else $error("output on with ground lost");
  a_uv_off_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
    clk_en_i && uv_act |=> !switch_on_o && !fault_indicator_n_o && flag_q)
    else $error("supply low not handled");
  a_uv_hold_cmd: assert property (@(posedge clk_i) disable iff (!rstn_i)
    clk_en_i && uv_latched_q && cmd |=> !fault_indicator_n_o && !switch_on_o)
    else $error("supply latch released early");
  a_uv_disabled: assert property (@(posedge clk_i) disable iff (!rstn_i)
    clk_en_i && supply_low_protect_disable && !$past(uv_act) && !uv_latched_q && !flag_q |=> !flag_q)
    else $error("flag set while disabled");
  a_cmd_on_or: assert property (@(posedge clk_i) disable iff (!rstn_i)
    clk_en_i && st_q == SWFLT_OFF && drive_i && !uv_act && !sense.gnd_lost && !uv_latched_q |=> switch_on_o)
    else $error("direct drive ignored");

  c_high_trip: cover property (@(posedge clk_i) st_q == SWFLT_ON ##1 st_q == SWFLT_TRIP);
  c_recover: cover property (@(posedge clk_i) st_q == SWFLT_WAIT_OFF ##1 st_q == SWFLT_OFF ##[1:5] switch_on_o);
  c_uv_latch: cover property (@(posedge clk_i) uv_latched_q && !cmd);

endmodule
`default_nettype wire

// ==== rtl/swflt_consts.svh ====
`ifndef SWFLT_CONSTS_SVH
`define SWFLT_CONSTS_SVH

// Register byte offsets
`define SWFLT_OFF_CTRL 12'h000
`define SWFLT_OFF_CFG 12'h004
`define SWFLT_OFF_STAT 12'h008
`define SWFLT_OFF_IRQ_STAT 12'h00c
`define SWFLT_OFF_IRQ_CLR 12'h010
`define SWFLT_OFF_IRQ_EN 12'h014
`define SWFLT_OFF_FLAG 12'h018

// CTRL fields
`define SWFLT_CTRL_CMD 0
`define SWFLT_CTRL_UVDIS 1
// CFG fields
`define SWFLT_CFG_LOW_LSB 0
`define SWFLT_CFG_HIGH 3
`define SWFLT_CFG_BLANK_LSB 4
// Interrupt bits
`define SWFLT_IRQ_LOW 0
`define SWFLT_IRQ_HIGH 1
`define SWFLT_IRQ_UV 2
`define SWFLT_IRQ_GND 3

`define SWFLT_CFG_RESET 32'h0000_0000
`define SWFLT_CTRL_RESET 32'h0000_0000

// Blanking times in ns per two-bit code
`define SWFLT_BLANK0_NS 1000
`define SWFLT_BLANK1_NS 2000
`define SWFLT_BLANK2_NS 4000
`define SWFLT_BLANK3_NS 8000
`define SWFLT_CLK_NS 8
`define SWFLT_CYC(ns) (((ns) + `SWFLT_CLK_NS - 1) / `SWFLT_CLK_NS)

`endif

// ==== rtl/swflt_pkg.sv ====
package swflt_pkg;

  typedef enum logic [1:0] {
    SWFLT_OFF = 2'b00,
    SWFLT_ON = 2'b01,
    SWFLT_TRIP = 2'b11,
    SWFLT_WAIT_OFF = 2'b10
  } swflt_state_type;

  typedef struct packed {
    logic low_reached;
    logic high_reached;
    logic supply_low;
    logic gnd_lost;
  } swflt_sense_type;

  typedef struct packed {
    logic [2:0] low_sel;
    logic high_sel;
    logic [1:0] blank_sel;
  } swflt_cfg_type;

endpackage

// ==== rtl/swflt_blank_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "swflt_consts.svh"
module swflt_blank_timer
  import swflt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic over_i,
  input wire logic [1:0] sel_i,
  output logic expired_o
);

  logic [10:0] cnt_q, cnt_d;

  function automatic logic [10:0] blank_cycles(input logic [1:0] sel);
    case (sel)
      2'd0: blank_cycles = 11'(`SWFLT_CYC(`SWFLT_BLANK0_NS));
      2'd1: blank_cycles = 11'(`SWFLT_CYC(`SWFLT_BLANK1_NS));
      2'd2: blank_cycles = 11'(`SWFLT_CYC(`SWFLT_BLANK2_NS));
      default: blank_cycles = 11'(`SWFLT_CYC(`SWFLT_BLANK3_NS));
    endcase
  endfunction

  always_comb begin
    cnt_d = cnt_q;
    if (!over_i) begin
      cnt_d = '0;
    end else if (cnt_q <= blank_cycles(sel_i)) begin
      cnt_d = cnt_q + 11'h001;
    end
  end

  // Expires once the condition has stood longer than the blanking period
  assign expired_o = over_i && (cnt_q > blank_cycles(sel_i));

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 11'h000;
    end else if (en_i) begin
      cnt_q <= cnt_d;
    end
  end

  a_blank_clears: assert property (@(posedge clk_i) disable iff (!rstn_i)
    en_i && !over_i |=> cnt_q == 11'h000) else $error("blank timer not cleared");

endmodule
`default_nettype wire

// ==== rtl/swflt_apb_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "swflt_consts.svh"
module swflt_apb_regs
  import swflt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [3:0] events_i,
  input wire logic [31:0] stat_i,
  input wire logic uv_flag_i,
  output logic [31:0] ctrl_o,
  output logic [31:0] cfg_o,
  output logic flag_read_o,
  output logic irq_o
);

  logic [31:0] ctrl_q, ctrl_d, cfg_q, cfg_d, rdata_q, rdata_d;
  logic [3:0] ist_q, ist_d, ien_q, ien_d;
  logic rdy_q, rdy_d, err_q, err_d, irq_q, irq_d, frd_q, frd_d;
  logic acc, wr, rd;

  always_comb begin
    acc = psel_i && penable_i && !rdy_q;
    wr = acc && pwrite_i;
    rd = acc && !pwrite_i;
    ctrl_d = ctrl_q;
    cfg_d = cfg_q;
    ien_d = ien_q;
    ist_d = ist_q;
    rdata_d = rdata_q;
    err_d = 1'b0;
    frd_d = 1'b0;
    rdy_d = acc;
    if (wr) begin
      case (paddr_i)
        `SWFLT_OFF_CTRL: ctrl_d = pwdata_i & 32'h0000_0003;
        `SWFLT_OFF_CFG: cfg_d = pwdata_i & 32'h0000_003f;
        `SWFLT_OFF_IRQ_CLR: ist_d = ist_q & ~pwdata_i[3:0];
        `SWFLT_OFF_IRQ_EN: ien_d = pwdata_i[3:0];
        `SWFLT_OFF_STAT, `SWFLT_OFF_IRQ_STAT, `SWFLT_OFF_FLAG: ;
        default: err_d = 1'b1;
      endcase
    end
    if (rd) begin
      case (paddr_i)
        `SWFLT_OFF_CTRL: rdata_d = ctrl_q;
        `SWFLT_OFF_CFG: rdata_d = cfg_q;
        `SWFLT_OFF_STAT: rdata_d = stat_i;
        `SWFLT_OFF_IRQ_STAT: rdata_d = {28'h0, ist_q};
        `SWFLT_OFF_IRQ_EN: rdata_d = {28'h0, ien_q};
        `SWFLT_OFF_IRQ_CLR: rdata_d = 32'h0;
        `SWFLT_OFF_FLAG: begin
          rdata_d = {31'h0, uv_flag_i};
          frd_d = 1'b1;
        end
        default: begin
          rdata_d = 32'h0;
          err_d = 1'b1;
        end
      endcase
    end
    // Set wins over a same-cycle clear
    ist_d = ist_d | events_i;
    irq_d = |(ist_d & ien_d);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= `SWFLT_CTRL_RESET;
      cfg_q <= `SWFLT_CFG_RESET;
      rdata_q <= 32'h0;
      ist_q <= 4'h0;
      ien_q <= 4'h0;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      irq_q <= 1'b0;
      frd_q <= 1'b0;
    end else if (en_i) begin
      ctrl_q <= ctrl_d;
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
      ist_q <= ist_d;
      ien_q <= ien_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
      irq_q <= irq_d;
      frd_q <= frd_d;
    end
  end

  assign ctrl_o = ctrl_q;
  assign cfg_o = cfg_q;
  assign prdata_o = rdata_q;
  assign pready_o = rdy_q;
  assign pslverr_o = err_q;
  assign irq_o = irq_q;
  assign flag_read_o = frd_q;

endmodule
`default_nettype wire

// ==== testbench/swflt_mcu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module swflt_mcu_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic want_i,
  input wire logic [3:0] lag_i,
  output logic drive_o
);
  logic [3:0] wait_q;
  logic [1:0] off_q;
  // Each change of the command waits lag_i cycles; a turn-on also needs two off cycles first
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      drive_o <= 1'b0;
      wait_q <= 4'h0;
    end else if (want_i == drive_o) begin
      wait_q <= 4'h0;
    end else if (wait_q < lag_i || (want_i && off_q < 2'h2)) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      drive_o <= want_i;
      wait_q <= 4'h0;
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      off_q <= 2'h0;
    end else begin
      off_q <= drive_o ? 2'h0 : (off_q == 2'h3 ? off_q : off_q + 2'h1);
    end
  end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "swflt_consts.svh"
module testbench;
  typedef struct {
    logic [31:0] cfg;
    logic [7:0] lo;
    logic [1:0] hi;
    int hold;
    logic trip;
  } swflt_row_type;
  logic clk, rstn, psel, penable, pwrite, want, drive, supply, gnd;
  logic pready, pslverr, sw, fault_n, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] lo;
  logic [1:0] hi;
  logic [3:0] lag;
  int errors = 0;
  int total_checks = 0;
  // Blanking codes 0..3 last 125, 250, 500, 1000 cycles; holds sit well either side
  swflt_row_type rows [10] = '{
    '{32'h03, 8'h0f, 2'h0, 200, 1'b1},
    '{32'h03, 8'h07, 2'h0, 200, 1'b0},
    '{32'h07, 8'hff, 2'h0, 200, 1'b1},
    '{32'h10, 8'h01, 2'h0, 200, 1'b0},
    '{32'h10, 8'h01, 2'h0, 300, 1'b1},
    '{32'h20, 8'h01, 2'h0, 560, 1'b1},
    '{32'h30, 8'h01, 2'h0, 900, 1'b0},
    '{32'h00, 8'h00, 2'h1, 2, 1'b1},
    '{32'h08, 8'h00, 2'h1, 2, 1'b0},
    '{32'h38, 8'hff, 2'h3, 2, 1'b1}
  };
  swflt_top u_dut (.clk_i(clk), .rstn_i(rstn), .clk_en_i(1'b1), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .drive_i(drive), .low_trip_current_i(lo), .high_trip_current_i(hi),
    .supply_low_i(supply), .gnd_lost_i(gnd), .switch_on_o(sw), .fault_indicator_n_o(fault_n), .irq_o(irq));
  swflt_mcu_model u_mcu (.clk_i(clk), .rstn_i(rstn), .want_i(want), .lag_i(lag), .drive_o(drive));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (pready !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: no bus answer", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle one edge so a following call never rewrites psel in this time step
    @(posedge clk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic cmd(input logic v);
    int n;
    n = 0;
    want <= v;
    while (drive !== v && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (drive !== v) begin
      errors++;
      $display("unexpected at %0t: command not followed", $time);
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic hold(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic final_report();
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #(8 * 40000);
    errors++;
    final_report();
  end
  initial begin
    {psel, penable, pwrite, want, supply, gnd, rstn} = '0;
    {paddr, pwdata, lo, hi, lag} = '0;
    hold(12);
    rstn <= 1'b1;
    chk(sw, 0);
    chk(fault_n, 1);
    chk(irq, 0);
    rdc(`SWFLT_OFF_CTRL, 32'h0);
    rdc(`SWFLT_OFF_CFG, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, `SWFLT_OFF_CFG, rows[i].cfg);
      cmd(1'b1);
      chk(sw, 1);
      lo <= rows[i].lo;
      hi <= rows[i].hi;
      hold(rows[i].hold);
      lo <= 8'h0;
      hi <= 2'h0;
      hold(6);
      chk(sw, !rows[i].trip);
      chk(fault_n, !rows[i].trip);
      cmd(1'b0);
      cmd(1'b1);
      chk(sw, 1);
      chk(fault_n, 1);
      cmd(1'b0);
    end
    apb(1'b1, `SWFLT_OFF_IRQ_CLR, 32'hf);
    apb(1'b1, `SWFLT_OFF_IRQ_EN, 32'h2);
    for (int m = 0; m < 2; m++) begin
      cmd(1'b1);
      // Last row left the high level select at one
      hi <= 2'h2;
      hold(2);
      hi <= 2'h0;
      hold(3);
      chk(irq, m == 0);
      rdc(`SWFLT_OFF_IRQ_STAT, 32'h2);
      apb(1'b1, `SWFLT_OFF_IRQ_CLR, 32'h2);
      apb(1'b1, `SWFLT_OFF_IRQ_EN, 32'h1);
      chk(irq, 0);
      cmd(1'b0);
    end
    apb(1'b1, `SWFLT_OFF_CTRL, 32'h1);
    hold(3);
    chk(sw, 1);
    apb(1'b1, `SWFLT_OFF_CTRL, 32'h0);
    hold(3);
    chk(sw, 0);
    lag <= 4'h5;
    cmd(1'b1);
    supply <= 1'b1;
    hold(3);
    chk({sw, fault_n}, 2'b00);
    supply <= 1'b0;
    hold(5);
    chk({sw, fault_n}, 2'b00);
    rdc(`SWFLT_OFF_FLAG, 32'h1);
    rdc(`SWFLT_OFF_FLAG, 32'h0);
    cmd(1'b0);
    cmd(1'b1);
    chk({sw, fault_n}, 2'b11);
    cmd(1'b0);
    supply <= 1'b1;
    hold(3);
    chk(fault_n, 0);
    supply <= 1'b0;
    hold(3);
    chk(fault_n, 1);
    rdc(`SWFLT_OFF_FLAG, 32'h1);
    apb(1'b1, `SWFLT_OFF_CTRL, 32'h2);
    cmd(1'b1);
    supply <= 1'b1;
    hold(5);
    chk({sw, fault_n}, 2'b11);
    supply <= 1'b0;
    rdc(`SWFLT_OFF_FLAG, 32'h0);
    apb(1'b1, `SWFLT_OFF_CTRL, 32'h0);
    gnd <= 1'b1;
    hold(3);
    chk(sw, 0);
    cmd(1'b0);
    cmd(1'b1);
    chk(sw, 0);
    gnd <= 1'b0;
    cmd(1'b0);
    apb(1'b0, 12'h100, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    final_report();
  end
endmodule
`default_nettype wire
